// file: src/rssa_core.sv
// module: rotate, subtract and skip execution datapath with register port
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module rssa_core (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic op_valid_in,
  input wire rssa_pkg::rssa_op_t op_code_in,
  input wire logic [rssa_pkg::DATA_W-1:0] mem_data_in,
  input wire logic [rssa_pkg::DATA_W-1:0] imm_data_in,
  input wire logic [rssa_pkg::BSEL_W-1:0] bit_sel_in,
  input wire logic [rssa_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [rssa_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [rssa_pkg::DATA_W-1:0] reg_rdata_out,
  output logic [rssa_pkg::DATA_W-1:0] wreg_out,
  output logic [rssa_pkg::DATA_W-1:0] mem_wdata_out,
  output logic mem_we_out,
  output logic ready_out,
  output logic done_out,
  output logic skip_out,
  output logic borrow_inv_flag_out,
  output logic half_borrow_flag_out,
  output logic zero_flag_out,
  output logic signed_wrap_flag_out
);
  import rssa_pkg::*;

  // -----------------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------------
  function automatic logic rssa_is_skip(input rssa_op_t op);
    case (op)
      op_dec_skip_zero, op_dec_skip_zero_to_w, op_inc_skip_zero, op_inc_skip_zero_to_w,
      op_skip_bit_one, op_test_skip_zero, op_move_skip_zero: rssa_is_skip = 1'h1;
      default: rssa_is_skip = 1'h0;
    endcase
  endfunction

  function automatic logic rssa_is_sub(input rssa_op_t op);
    case (op)
      op_minus_with_borrow, op_minus_with_borrow_to_mem, op_minus_mem_to_w,
      op_minus_mem_to_mem, op_minus_imm_to_w: rssa_is_sub = 1'h1;
      default: rssa_is_sub = 1'h0;
    endcase
  endfunction

  // returns {wrap, zero, half_borrow, borrow_inv, result}
  function automatic logic [11:0] rssa_sub(input logic [7:0] a, input logic [7:0] b,
                                           input logic bin);
    logic [8:0] d;
    logic [4:0] hd;
    logic wrap;
    d = {1'h0, a} - {1'h0, b} - {8'h00, bin};
    hd = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, bin};
    wrap = (a[7] ^ b[7]) & (a[7] ^ d[7]);
    rssa_sub = {wrap, (d[7:0] == BYTE_ZERO), hd[4], ~d[8], d[7:0]};
  endfunction

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  rssa_state_t state_r;
  logic [7:0] wreg_r;
  logic [3:0] flags_r;
  logic [7:0] rdata_r;
  logic [7:0] mem_wdata_r;
  logic mem_we_r;
  logic ready_r;
  logic done_r;
  logic skip_r;
  logic skip_pend_r;
  logic last_skip_r;

  logic take;
  logic [7:0] res_nxt;
  logic wr_w;
  logic wr_mem;
  logic upd_binv;
  logic binv_nxt;
  logic skip_nxt;
  logic [7:0] sub_opnd;
  logic sub_bin;
  logic [11:0] sub_all;
  logic [7:0] bit_mask;

  assign take = op_valid_in & (state_r == st_idle);
  assign bit_mask = BYTE_ONE << bit_sel_in;
  assign sub_opnd = (op_code_in == op_minus_imm_to_w) ? imm_data_in : mem_data_in;
  assign sub_bin = ((op_code_in == op_minus_with_borrow) ||
                    (op_code_in == op_minus_with_borrow_to_mem)) ? ~flags_r[FLG_BINV] : 1'h0;
  assign sub_all = rssa_sub(wreg_r, sub_opnd, sub_bin);

  // -----------------------------------------------------------------------
  // operation datapath
  // -----------------------------------------------------------------------
  always_comb begin
    res_nxt = mem_data_in;
    wr_w = 1'h0;
    wr_mem = 1'h0;
    upd_binv = 1'h0;
    binv_nxt = flags_r[FLG_BINV];
    skip_nxt = 1'h0;
    case (op_code_in)
      op_rotate_left_thru_borrow_to_w: begin
        res_nxt = {mem_data_in[6:0], flags_r[FLG_BINV]};
        wr_w = 1'h1;
        upd_binv = 1'h1;
        binv_nxt = mem_data_in[7];
      end
      op_rotate_right: begin
        res_nxt = {mem_data_in[0], mem_data_in[7:1]};
        wr_mem = 1'h1;
      end
      op_rotate_right_to_w: begin
        res_nxt = {mem_data_in[0], mem_data_in[7:1]};
        wr_w = 1'h1;
      end
      op_rotate_right_thru_borrow: begin
        res_nxt = {flags_r[FLG_BINV], mem_data_in[7:1]};
        wr_mem = 1'h1;
        upd_binv = 1'h1;
        binv_nxt = mem_data_in[0];
      end
      op_rotate_right_thru_borrow_to_w: begin
        res_nxt = {flags_r[FLG_BINV], mem_data_in[7:1]};
        wr_w = 1'h1;
        upd_binv = 1'h1;
        binv_nxt = mem_data_in[0];
      end
      op_minus_with_borrow, op_minus_mem_to_w, op_minus_imm_to_w: begin
        res_nxt = sub_all[7:0];
        wr_w = 1'h1;
      end
      op_minus_with_borrow_to_mem, op_minus_mem_to_mem: begin
        res_nxt = sub_all[7:0];
        wr_mem = 1'h1;
      end
      op_dec_skip_zero: begin
        res_nxt = mem_data_in - BYTE_ONE;
        wr_mem = 1'h1;
        skip_nxt = (mem_data_in == BYTE_ONE);
      end
      op_dec_skip_zero_to_w: begin
        res_nxt = mem_data_in - BYTE_ONE;
        wr_w = 1'h1;
        skip_nxt = (mem_data_in == BYTE_ONE);
      end
      op_byte_set: begin
        res_nxt = BYTE_ONES;
        wr_mem = 1'h1;
      end
      op_bit_set: begin
        res_nxt = mem_data_in | bit_mask;
        wr_mem = 1'h1;
      end
      op_inc_skip_zero: begin
        res_nxt = mem_data_in + BYTE_ONE;
        wr_mem = 1'h1;
        skip_nxt = (mem_data_in == BYTE_ONES);
      end
      op_inc_skip_zero_to_w: begin
        res_nxt = mem_data_in + BYTE_ONE;
        wr_w = 1'h1;
        skip_nxt = (mem_data_in == BYTE_ONES);
      end
      op_skip_bit_one: begin
        skip_nxt = |(mem_data_in & bit_mask);
      end
      op_nibble_exchange: begin
        res_nxt = {mem_data_in[3:0], mem_data_in[7:4]};
        wr_mem = 1'h1;
      end
      op_nibble_exchange_to_w: begin
        res_nxt = {mem_data_in[3:0], mem_data_in[7:4]};
        wr_w = 1'h1;
      end
      op_test_skip_zero: begin
        wr_mem = 1'h1;
        skip_nxt = (mem_data_in == BYTE_ZERO);
      end
      op_move_skip_zero: begin
        wr_w = 1'h1;
        skip_nxt = (mem_data_in == BYTE_ZERO);
      end
      default: res_nxt = mem_data_in;
    endcase
  end

  // -----------------------------------------------------------------------
  // sequencing: skip operations hold a dummy cycle
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= st_idle;
      ready_r <= 1'h0;
      done_r <= 1'h0;
      skip_r <= 1'h0;
      skip_pend_r <= 1'h0;
    end else begin
      done_r <= 1'h0;
      skip_r <= 1'h0;
      ready_r <= 1'h1;
      case (state_r)
        st_idle: begin
          if (take && rssa_is_skip(op_code_in)) begin
            state_r <= st_dummy;
            ready_r <= 1'h0;
            skip_pend_r <= skip_nxt;
          end else if (take && (op_code_in != op_none)) begin
            done_r <= 1'h1;
          end
        end
        st_dummy: begin
          state_r <= st_idle;
          done_r <= 1'h1;
          skip_r <= skip_pend_r;
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // working register: operation wins over a software write
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wreg_r <= WREG_RST;
    end else if (take && wr_w) begin
      wreg_r <= res_nxt;
    end else if (reg_wr_in && (reg_addr_in == REG_WREG_OFS)) begin
      wreg_r <= reg_wdata_in;
    end
  end

  // -----------------------------------------------------------------------
  // flags: only subtracts, borrow rotates and a software write to the flags register touch them
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_r <= FLAGS_RST;
    end else if (take && rssa_is_sub(op_code_in)) begin
      flags_r <= sub_all[11:8];
    end else if (take && upd_binv) begin
      flags_r[FLG_BINV] <= binv_nxt;
    end else if (reg_wr_in && (reg_addr_in == REG_FLAGS_OFS)) begin
      flags_r <= reg_wdata_in[3:0];
    end
  end

  // -----------------------------------------------------------------------
  // memory write-back, one cycle after the operation
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_we_r <= 1'h0;
      mem_wdata_r <= BYTE_ZERO;
    end else begin
      mem_we_r <= take & wr_mem;
      if (take && wr_mem) begin
        mem_wdata_r <= res_nxt;
      end
    end
  end

  // -----------------------------------------------------------------------
  // register read port
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_skip_r <= 1'h0;
    end else if (state_r == st_dummy) begin
      last_skip_r <= skip_pend_r;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= BYTE_ZERO;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        REG_WREG_OFS: rdata_r <= wreg_r;
        REG_FLAGS_OFS: rdata_r <= {4'h0, flags_r};
        REG_STATUS_OFS: rdata_r <= {6'h00, last_skip_r, (state_r != st_idle)};
        default: rdata_r <= BYTE_ZERO;
      endcase
    end else begin
      rdata_r <= BYTE_ZERO;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign wreg_out = wreg_r;
  assign mem_wdata_out = mem_wdata_r;
  assign mem_we_out = mem_we_r;
  assign ready_out = ready_r;
  assign done_out = done_r;
  assign skip_out = skip_r;
  assign borrow_inv_flag_out = flags_r[FLG_BINV];
  assign half_borrow_flag_out = flags_r[FLG_HALF];
  assign zero_flag_out = flags_r[FLG_ZERO];
  assign signed_wrap_flag_out = flags_r[FLG_WRAP];

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  logic [7:0] chk_mem_r;
  logic [7:0] chk_w_r;
  logic [7:0] chk_opnd_r;
  logic [3:0] chk_flags_r;
  logic chk_bin_r;
  rssa_op_t chk_op_r;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chk_mem_r <= BYTE_ZERO;
      chk_w_r <= BYTE_ZERO;
      chk_opnd_r <= BYTE_ZERO;
      chk_flags_r <= FLAGS_RST;
      chk_bin_r <= 1'h0;
      chk_op_r <= op_none;
    end else if (take) begin
      chk_mem_r <= mem_data_in;
      chk_w_r <= wreg_r;
      chk_opnd_r <= sub_opnd;
      chk_flags_r <= flags_r;
      chk_bin_r <= sub_bin;
      chk_op_r <= op_code_in;
    end
  end

  a_rot_left_w: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && op_code_in == op_rotate_left_thru_borrow_to_w |=>
      wreg_r == {chk_mem_r[6:0], chk_flags_r[FLG_BINV]} &&
      flags_r[FLG_BINV] == chk_mem_r[7] && !mem_we_r)
    else $error("left rotate through borrow wrong");

  a_rot_right_plain: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && (op_code_in == op_rotate_right || op_code_in == op_rotate_right_to_w) |=>
      flags_r == chk_flags_r && (mem_we_r ? mem_wdata_r : wreg_r) ==
      {chk_mem_r[0], chk_mem_r[7:1]} && (mem_we_r == (chk_op_r == op_rotate_right)))
    else $error("plain right rotate wrong");

  a_rot_right_borrow: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && (op_code_in == op_rotate_right_thru_borrow ||
             op_code_in == op_rotate_right_thru_borrow_to_w) |=>
      (mem_we_r ? mem_wdata_r : wreg_r) == {chk_flags_r[FLG_BINV], chk_mem_r[7:1]} &&
      flags_r == {chk_flags_r[3:1], chk_mem_r[0]})
    else $error("right rotate through borrow wrong");

  a_sub_borrow_flag: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && rssa_is_sub(op_code_in) |=>
      flags_r[FLG_BINV] == ({1'h0, chk_w_r} >= ({1'h0, chk_opnd_r} + {8'h00, chk_bin_r})))
    else $error("borrow flag wrong after subtract");

  a_sub_result: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && rssa_is_sub(op_code_in) |=>
      (mem_we_r ? mem_wdata_r : wreg_r) == 8'(chk_w_r - chk_opnd_r - {7'h00, chk_bin_r}) &&
      flags_r[FLG_ZERO] == ((mem_we_r ? mem_wdata_r : wreg_r) == BYTE_ZERO))
    else $error("subtract result or zero flag wrong");

  a_skip_timing: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && rssa_is_skip(op_code_in) |=> !ready_out && !done_out ##1 done_out && ready_out)
    else $error("skip operation not two cycles");
  a_single_cycle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && !rssa_is_skip(op_code_in) && op_code_in != op_none |=>
      done_out && ready_out && !skip_out)
    else $error("plain operation not one cycle");
  a_dec_skip: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && (op_code_in == op_dec_skip_zero || op_code_in == op_dec_skip_zero_to_w) |=>
      (mem_we_r ? mem_wdata_r : wreg_r) == 8'(chk_mem_r - BYTE_ONE) &&
      flags_r == chk_flags_r ##1 skip_out == (chk_mem_r == BYTE_ONE))
    else $error("decrement skip wrong");
  a_inc_skip: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && (op_code_in == op_inc_skip_zero || op_code_in == op_inc_skip_zero_to_w) |=>
      (mem_we_r ? mem_wdata_r : wreg_r) == 8'(chk_mem_r + BYTE_ONE) &&
      flags_r == chk_flags_r ##1 skip_out == (chk_mem_r == BYTE_ONES))
    else $error("increment skip wrong");
  a_set_ops: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && (op_code_in == op_byte_set || op_code_in == op_bit_set) |=>
      mem_we_r && flags_r == chk_flags_r && mem_wdata_r == ((chk_op_r == op_byte_set) ?
      BYTE_ONES : (chk_mem_r | (BYTE_ONE << $past(bit_sel_in)))))
    else $error("set operation wrong");
  a_nibble_swap: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && (op_code_in == op_nibble_exchange || op_code_in == op_nibble_exchange_to_w) |=>
      (mem_we_r ? mem_wdata_r : wreg_r) == {chk_mem_r[3:0], chk_mem_r[7:4]} &&
      flags_r == chk_flags_r)
    else $error("nibble exchange wrong");
  a_zero_skip: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    take && (op_code_in == op_test_skip_zero || op_code_in == op_move_skip_zero) |=>
      (mem_we_r ? mem_wdata_r : wreg_r) == chk_mem_r ##1
      skip_out == (chk_mem_r == BYTE_ZERO))
    else $error("zero test skip wrong");

endmodule

// file: src/rssa_pkg.sv
// package: constants and types for the rotate, subtract and skip datapath
// -----------------------------------------------------------------------
package rssa_pkg;

  // -----------------------------------------------------------------------
  // widths
  // -----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int BSEL_W = 3;
  localparam int FLAG_W = 4;

  // -----------------------------------------------------------------------
  // register map and field positions
  // -----------------------------------------------------------------------
  localparam logic [7:0] REG_WREG_OFS = 8'h00;
  localparam logic [7:0] REG_FLAGS_OFS = 8'h04;
  localparam logic [7:0] REG_STATUS_OFS = 8'h08;
  localparam int FLG_BINV = 0;
  localparam int FLG_HALF = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_WRAP = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;

  // -----------------------------------------------------------------------
  // reset values and data constants
  // -----------------------------------------------------------------------
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int SKIP_OP_CYCLES = 2;

  // -----------------------------------------------------------------------
  // operations and sequencing states
  // -----------------------------------------------------------------------
  typedef enum logic [4:0] {
    op_none,
    op_rotate_left_thru_borrow_to_w,
    op_rotate_right,
    op_rotate_right_to_w,
    op_rotate_right_thru_borrow,
    op_rotate_right_thru_borrow_to_w,
    op_minus_with_borrow,
    op_minus_with_borrow_to_mem,
    op_dec_skip_zero,
    op_dec_skip_zero_to_w,
    op_byte_set,
    op_bit_set,
    op_inc_skip_zero,
    op_inc_skip_zero_to_w,
    op_skip_bit_one,
    op_minus_mem_to_w,
    op_minus_mem_to_mem,
    op_minus_imm_to_w,
    op_nibble_exchange,
    op_nibble_exchange_to_w,
    op_test_skip_zero,
    op_move_skip_zero
  } rssa_op_t;

  typedef enum logic {
    st_idle,
    st_dummy
  } rssa_state_t;

endpackage

// file: verif/rssa_mem_model.sv
// data memory byte model feeding the datapath and taking its write-backs
`timescale 1ns/10ps
module rssa_mem_model (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [7:0] load_data_in,
  input wire logic mem_we_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_data_out
);
  // bench preload wins, else the block's write-back lands
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_data_out <= 8'h00;
    end else if (load_in) begin
      mem_data_out <= load_data_in;
    end else if (mem_we_in) begin
      mem_data_out <= mem_wdata_in;
    end
  end
endmodule

// file: verif/rssa_core_tb.sv
// self-checking bench for the rotate, subtract and skip datapath
`timescale 1ns/10ps
module rssa_core_tb;
  import rssa_pkg::*;
  logic clk, rstn, op_valid, ld, wr, rd, we, ready, done, skip, binv, half, zero, wrap;
  rssa_op_t op_code;
  logic [7:0] mem_byte, imm, ld_data, addr, wdata, rdata, wreg, wdat;
  logic [2:0] bit_sel;
  int bad_count, cmp_count;

  rssa_core u_rssa_core (.clk_sys_in(clk), .rstn_in(rstn), .op_valid_in(op_valid),
    .op_code_in(op_code), .mem_data_in(mem_byte), .imm_data_in(imm), .bit_sel_in(bit_sel),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .wreg_out(wreg), .mem_wdata_out(wdat), .mem_we_out(we),
    .ready_out(ready), .done_out(done), .skip_out(skip), .borrow_inv_flag_out(binv),
    .half_borrow_flag_out(half), .zero_flag_out(zero), .signed_wrap_flag_out(wrap));
  rssa_mem_model u_rssa_mem_model (.clk_sys_in(clk), .rstn_in(rstn), .load_in(ld),
    .load_data_in(ld_data), .mem_we_in(we), .mem_wdata_in(wdat), .mem_data_out(mem_byte));

  // -----------------------------------------------------------------------
  // clock, checking and verdict
  // -----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // -----------------------------------------------------------------------
  // access tasks
  // -----------------------------------------------------------------------
  task reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // one operation: preload memory, issue, check results and skip timing
  task run(input rssa_op_t op, input logic [7:0] m, input logic [2:0] bs,
           input logic [7:0] im, input logic sk, input logic [7:0] ew,
           input logic [7:0] em, input logic [3:0] ef, input logic es);
    @(posedge clk);
    ld <= 1'b1;
    ld_data <= m;
    @(posedge clk);
    ld <= 1'b0;
    op_valid <= 1'b1;
    op_code <= op;
    bit_sel <= bs;
    imm <= im;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    check(wreg, ew);
    check({4'h0, wrap, zero, half, binv}, {4'h0, ef});
    check({5'h0, done, ready, skip}, sk ? 8'h00 : 8'h06);
    @(posedge clk);
    #1;
    check(mem_byte, em);
    check({6'h0, done, skip}, {6'h0, sk, sk & es});
  endtask

  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  // -----------------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    {op_valid, ld, wr, rd} = 4'h0;
    op_code = op_none;
    {imm, ld_data, addr, wdata} = 32'h0;
    bit_sel = 3'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(8'h04, 8'h00);
    reg_rd(8'h0c, 8'h00);
    reg_wr(8'h04, 8'h01);
    run(op_rotate_left_thru_borrow_to_w, 8'h81, 3'h0, 8'h00, 0, 8'h03, 8'h81, 4'h1, 0);
    run(op_rotate_right, 8'h01, 3'h0, 8'h00, 0, 8'h03, 8'h80, 4'h1, 0);
    run(op_rotate_right_to_w, 8'h02, 3'h0, 8'h00, 0, 8'h01, 8'h02, 4'h1, 0);
    run(op_rotate_right_thru_borrow, 8'h02, 3'h0, 8'h00, 0, 8'h01, 8'h81, 4'h0, 0);
    run(op_rotate_right_thru_borrow_to_w, 8'h01, 3'h0, 8'h00, 0, 8'h00, 8'h01, 4'h1, 0);
    reg_wr(8'h00, 8'h10);
    run(op_minus_mem_to_w, 8'h01, 3'h0, 8'h00, 0, 8'h0f, 8'h01, 4'h3, 0);
    run(op_minus_with_borrow, 8'h0f, 3'h0, 8'h00, 0, 8'h00, 8'h0f, 4'h5, 0);
    run(op_minus_with_borrow_to_mem, 8'h01, 3'h0, 8'h00, 0, 8'h00, 8'hff, 4'h2, 0);
    run(op_minus_with_borrow, 8'h00, 3'h0, 8'h00, 0, 8'hff, 8'h00, 4'h2, 0);
    reg_wr(8'h00, 8'h80);
    run(op_minus_imm_to_w, 8'h55, 3'h0, 8'h01, 0, 8'h7f, 8'h55, 4'hb, 0);
    run(op_minus_mem_to_mem, 8'h80, 3'h0, 8'h00, 0, 8'h7f, 8'hff, 4'h8, 0);
    reg_rd(8'h04, 8'h08);
    run(op_byte_set, 8'h12, 3'h0, 8'h00, 0, 8'h7f, 8'hff, 4'h8, 0);
    run(op_bit_set, 8'h41, 3'h5, 8'h00, 0, 8'h7f, 8'h61, 4'h8, 0);
    run(op_nibble_exchange, 8'h1e, 3'h0, 8'h00, 0, 8'h7f, 8'he1, 4'h8, 0);
    run(op_nibble_exchange_to_w, 8'h3c, 3'h0, 8'h00, 0, 8'hc3, 8'h3c, 4'h8, 0);
    run(op_dec_skip_zero, 8'h01, 3'h0, 8'h00, 1, 8'hc3, 8'h00, 4'h8, 1);
    run(op_dec_skip_zero, 8'h00, 3'h0, 8'h00, 1, 8'hc3, 8'hff, 4'h8, 0);
    run(op_dec_skip_zero_to_w, 8'h01, 3'h0, 8'h00, 1, 8'h00, 8'h01, 4'h8, 1);
    run(op_dec_skip_zero_to_w, 8'h05, 3'h0, 8'h00, 1, 8'h04, 8'h05, 4'h8, 0);
    run(op_inc_skip_zero, 8'hff, 3'h0, 8'h00, 1, 8'h04, 8'h00, 4'h8, 1);
    run(op_inc_skip_zero, 8'h7f, 3'h0, 8'h00, 1, 8'h04, 8'h80, 4'h8, 0);
    run(op_inc_skip_zero_to_w, 8'hff, 3'h0, 8'h00, 1, 8'h00, 8'hff, 4'h8, 1);
    run(op_inc_skip_zero_to_w, 8'h05, 3'h0, 8'h00, 1, 8'h06, 8'h05, 4'h8, 0);
    run(op_skip_bit_one, 8'h08, 3'h3, 8'h00, 1, 8'h06, 8'h08, 4'h8, 1);
    run(op_skip_bit_one, 8'hf7, 3'h3, 8'h00, 1, 8'h06, 8'hf7, 4'h8, 0);
    run(op_test_skip_zero, 8'h00, 3'h0, 8'h00, 1, 8'h06, 8'h00, 4'h8, 1);
    run(op_test_skip_zero, 8'h9a, 3'h0, 8'h00, 1, 8'h06, 8'h9a, 4'h8, 0);
    run(op_move_skip_zero, 8'h00, 3'h0, 8'h00, 1, 8'h00, 8'h00, 4'h8, 1);
    reg_rd(8'h08, 8'h02);
    run(op_move_skip_zero, 8'h44, 3'h0, 8'h00, 1, 8'h44, 8'h44, 4'h8, 0);
    reg_rd(8'h00, 8'h44);
    give_verdict();
  end
endmodule
